// ### src/ldm_led_dim_regs.sv
// register group for led dimming, port function and sense readout
`timescale 1ns/10ps
`default_nettype none
`include "ldm_map.svh"
module ldm_led_dim_regs import ldm_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [7:0] touch_in,
  input wire logic [7:0] chan_hi_a_in,
  input wire logic [1:0] chan_lo_a_in,
  input wire logic [7:0] chan_hi_b_in,
  input wire logic [1:0] chan_lo_b_in,
  input wire logic [25:0] touch_ratio_in,
  output logic [7:0] port_low_out,
  output logic [7:0] port_out_out,
  output logic [7:0] port_oe_n_out
);
  ldm_byte_type dim_q [4];
  ldm_byte_type func_q;
  ldm_byte_type rdata_q;
  logic rvalid_q;
  ldm_rd_state_type rd_state_q;
  ldm_byte_type rd_mux;
  logic [31:0] levels;
  logic [7:0] oe_n;
  logic [7:0] oe_n_q;
  logic [7:0] low_pin_q;
  ldm_pwm_if pwm_bus ();

  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_dim
      always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
          dim_q[k] <= `LDM_DIM_RESET;
        end else if (reg_wr_in && reg_addr_in == 8'(`LDM_ADDR_DIM_12 + k)) begin
          dim_q[k] <= reg_wdata_in;
        end
      end
      assign levels[8*k +: 4] = dim_q[k][3:0];
      assign levels[8*k+4 +: 4] = dim_q[k][7:4];
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      func_q <= `LDM_FUNC_RESET;
    end else if (reg_wr_in && reg_addr_in == `LDM_ADDR_OUT_FUNC) begin
      func_q <= reg_wdata_in;
    end
  end

  // readout addresses have no write path at all
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr_in)
      `LDM_ADDR_DIM_12: rd_mux = dim_q[0];
      `LDM_ADDR_DIM_34: rd_mux = dim_q[1];
      `LDM_ADDR_DIM_56: rd_mux = dim_q[2];
      `LDM_ADDR_DIM_78: rd_mux = dim_q[3];
      `LDM_ADDR_OUT_FUNC: rd_mux = func_q;
      `LDM_ADDR_CHAN_HI_A: rd_mux = chan_hi_a_in & 8'hfe;
      `LDM_ADDR_CHAN_LO_A: rd_mux = {6'h00, chan_lo_a_in};
      `LDM_ADDR_RATIO_HI: rd_mux = touch_ratio_in[25:18];
      `LDM_ADDR_RATIO_MID: rd_mux = touch_ratio_in[17:10];
      `LDM_ADDR_RATIO_LO: rd_mux = touch_ratio_in[9:2];
      `LDM_ADDR_CHAN_HI_B: rd_mux = chan_hi_b_in & 8'hfe;
      `LDM_ADDR_CHAN_LO_B: rd_mux = {6'h00, chan_lo_b_in};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_state_q <= LDM_IDLE;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      unique case (rd_state_q)
        LDM_IDLE: begin
          rvalid_q <= 1'b0;
          if (reg_rd_in) begin
            rdata_q <= rd_mux;
            rvalid_q <= 1'b1;
            rd_state_q <= LDM_READ;
          end
        end
        LDM_READ: begin
          rvalid_q <= 1'b0;
          rd_state_q <= LDM_IDLE;
        end
        // stray code falls back to idle
        default: begin
          rvalid_q <= 1'b0;
          rd_state_q <= LDM_IDLE;
        end
      endcase
    end
  end

  ldm_pwm_base u_base (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pwm(pwm_bus.src)
  );

  ldm_port_drv u_drv (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pwm(pwm_bus.dst),
    .levels_in(levels),
    .func_in(func_q),
    .touch_in(touch_in),
    .port_oe_n_out(oe_n)
  );

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oe_n_q <= 8'hff;
      low_pin_q <= 8'h00;
    end else begin
      oe_n_q <= oe_n;
      low_pin_q <= ~oe_n;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
  assign port_oe_n_out = oe_n_q;
  assign port_low_out = low_pin_q;
  assign port_out_out = 8'h00;
endmodule // ldm_led_dim_regs
`default_nettype wire

// ### src/ldm_map.svh
// register offsets, field positions, reset values and timing counts for the led dim block
// How it works
// - four dim registers, odd port low nibble
// - levels reset zero, duty grows monotonically
// - output function register, bit n-1 port n
// - function bit chooses touch or LED
// - readout identifies channel of sense count
// - high byte one-hot noise and inputs 1-6
// - low byte 01 input 7, 10 input 8
// - second identical channel indication register pair
// - percentage bits 25:2 over three bytes
// - readout registers ignore writes entirely
// - internal power-on reset sets reset state; here there is none, only the reset_in input sets it
// - touch result one means touched
`ifndef LDM_MAP_SVH
`define LDM_MAP_SVH
`define LDM_ADDR_DIM_12 8'h43
`define LDM_ADDR_DIM_34 8'h44
`define LDM_ADDR_DIM_56 8'h45
`define LDM_ADDR_DIM_78 8'h46
`define LDM_ADDR_OUT_FUNC 8'h4f
`define LDM_ADDR_CHAN_HI_A 8'h50
`define LDM_ADDR_CHAN_LO_A 8'h51
`define LDM_ADDR_RATIO_HI 8'h52
`define LDM_ADDR_RATIO_MID 8'h53
`define LDM_ADDR_RATIO_LO 8'h54
`define LDM_ADDR_CHAN_HI_B 8'h56
`define LDM_ADDR_CHAN_LO_B 8'h57
`define LDM_DIM_RESET 8'h00
`define LDM_FUNC_RESET 8'h00
`define LDM_RATIO_HI_MSB 25
`define LDM_RATIO_LO_LSB 2
`define LDM_CHAN_LO_MASK 8'h03
`define LDM_PWM_PERIOD_NS 2560
`define LDM_CLK_PERIOD_NS 10
`define LDM_PWM_STEP_CYCLES ((`LDM_PWM_PERIOD_NS / `LDM_CLK_PERIOD_NS) / 16)
`endif

// ### src/ldm_pkg.sv
// types shared by the led dim block
`default_nettype none
package ldm_pkg;
  typedef logic [3:0] ldm_level_type;
  typedef logic [7:0] ldm_byte_type;
  typedef enum logic [1:0] {
    LDM_IDLE = 2'b01,
    LDM_READ = 2'b10
  } ldm_rd_state_type;
endpackage
`default_nettype wire

// ### src/ldm_pwm_if.sv
// shared pwm phase between the timebase and the port drivers
`timescale 1ns/10ps
`default_nettype none
interface ldm_pwm_if;
  logic [3:0] phase;
  modport src (output phase);
  modport dst (input phase);
endinterface
`default_nettype wire

// ### src/ldm_pwm_base.sv
// pwm phase counter for the led ports
`timescale 1ns/10ps
`default_nettype none
`include "ldm_map.svh"
module ldm_pwm_base import ldm_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  ldm_pwm_if.src pwm
);
  logic [7:0] step_q;
  logic [3:0] phase_q;
  localparam logic [7:0] STEP_LAST = 8'(`LDM_PWM_STEP_CYCLES - 1);
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      step_q <= 8'h00;
      phase_q <= 4'h0;
    end else if (step_q == STEP_LAST) begin
      step_q <= 8'h00;
      phase_q <= phase_q + 4'h1;
    end else begin
      step_q <= step_q + 8'h01;
    end
  end
  assign pwm.phase = phase_q;
endmodule // ldm_pwm_base
`default_nettype wire

// ### src/ldm_port_drv.sv
// per-port output selection between touch result and dimmed led
`timescale 1ns/10ps
`default_nettype none
module ldm_port_drv import ldm_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  ldm_pwm_if.dst pwm,
  input wire logic [31:0] levels_in,
  input wire logic [7:0] func_in,
  input wire logic [7:0] touch_in,
  output logic [7:0] port_oe_n_out
);
  logic [7:0] low_q;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_port
      always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
          low_q[i] <= 1'b0;
        end else if (func_in[i]) begin
          low_q[i] <= pwm.phase <= levels_in[4*i +: 4];
        end else begin
          low_q[i] <= touch_in[i];
        end
      end
    end
  endgenerate
  assign port_oe_n_out = ~low_q;
endmodule // ldm_port_drv
`default_nettype wire

// ### dv/ldm_checker.sv
// port assertions for the led dim register block
`timescale 1ns/10ps
`default_nettype none
module ldm_checker (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [7:0] touch_in,
  input wire logic [7:0] chan_hi_a_in,
  input wire logic [1:0] chan_lo_a_in,
  input wire logic [25:0] touch_ratio_in,
  input wire logic [7:0] chan_hi_b_in,
  input wire logic [7:0] port_oe_n_out,
  input wire logic [7:0] port_low_out,
  input wire logic [7:0] port_out_out
);
  logic rd_q;
  logic [7:0] fq_q;
  logic [3:0] dq_q;
  // shadow of function bits and port 1 level
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_q <= 1'b0;
      fq_q <= 8'h00;
      dq_q <= 4'h0;
    end else begin
      rd_q <= reg_rd_in;
      if (reg_wr_in && reg_addr_in == 8'h4f) fq_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 8'h43) dq_q <= reg_wdata_in[3:0];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  a_read_answer: assert property (reg_rd_in && !rd_q |=> reg_rvalid_out)
    else $error("read not answered");
  a_answer_once: assert property (reg_rvalid_out |=> !reg_rvalid_out)
    else $error("answer too long");
  a_no_stray: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("answer without read");
  a_chan_hi_sel: assert property (reg_rd_in && !rd_q && reg_addr_in == 8'h50 |=>
    reg_rdata_out == {$past(chan_hi_a_in[7:1]), 1'b0}) else $error("high index wrong");
  a_chan_lo_sel: assert property (reg_rd_in && !rd_q && reg_addr_in == 8'h51 |=>
    reg_rdata_out == {6'h00, $past(chan_lo_a_in)}) else $error("low index wrong");
  a_ratio_low: assert property (reg_rd_in && !rd_q && reg_addr_in == 8'h54 |=>
    reg_rdata_out == $past(touch_ratio_in[9:2])) else $error("ratio byte wrong");
  a_parallel_port: assert property (fq_q == 8'h00 && $past(fq_q, 2) == 8'h00 &&
    $stable(touch_in) && touch_in == $past(touch_in, 2) && !$past(reset_in, 2)
    |-> port_oe_n_out == ~touch_in) else $error("parallel port wrong");
  a_full_dim: assert property (fq_q[0] && $past(fq_q[0], 2) && dq_q == 4'hf &&
    $past(dq_q, 2) == 4'hf |-> !port_oe_n_out[0]) else $error("full level not low");
  a_low_mirror: assert property (port_low_out == ~port_oe_n_out)
    else $error("low flags disagree with enables");
  a_drain_zero: assert property (port_out_out == 8'h00)
    else $error("open-drain data not zero");
  a_chan_hi_b: assert property (reg_rd_in && !rd_q && reg_addr_in == 8'h56 |=>
    reg_rdata_out == {$past(chan_hi_b_in[7:1]), 1'b0}) else $error("second index wrong");
endmodule // ldm_checker
bind ldm_led_dim_regs ldm_checker u_ldm_checker (.*);
`default_nettype wire

// ### dv/ldm_led_load.sv
// led load on the open-drain ports
`timescale 1ns/10ps
`default_nettype none
module ldm_led_load (
  input wire logic [7:0] port_oe_n_in,
  output logic [7:0] pin_out
);
  // released pin is pulled up by the load
  assign pin_out = port_oe_n_in;
endmodule // ldm_led_load
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the led dim register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk_in = 0, reset_in = 1, wr = 0, rd = 0, rvalid;
  logic [7:0] addr = 0, wdata = 0, touch = 0, hia = 8'h04, hib = 8'h81, rdata, oe_n, pin;
  logic [1:0] loa = 2'h1, lob = 2'h2;
  logic [25:0] ratio = 26'h2ab_cdef;
  int failures = 0, num_checks = 0, n, lo[8];
  logic [7:0] exp_lo [8] = '{8'h10, 8'h01, 8'h0c, 8'h06, 8'h0d, 8'h06, 8'h0e, 8'h06};
  always #5 ref_clk_in = ~ref_clk_in;
  ldm_led_dim_regs u_ldm_led_dim_regs (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .touch_in(touch), .chan_hi_a_in(hia),
    .chan_lo_a_in(loa), .chan_hi_b_in(hib), .chan_lo_b_in(lob), .touch_ratio_in(ratio),
    .port_low_out(), .port_out_out(), .port_oe_n_out(oe_n));
  ldm_led_load u_ldm_led_load (.port_oe_n_in(oe_n), .pin_out(pin));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in) #1 {wr, addr, wdata} = {1'b1, a, d};
    @(posedge ref_clk_in) #1 wr = 0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in) #1 {rd, addr} = {1'b1, a};
    @(posedge ref_clk_in) #1 rd = 0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000 failures++;
    results;
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1 reset_in = 0;
    for (n = 0; n < 4; n++) rd_reg(8'h43 + 8'(n), 8'h00);
    rd_reg(8'h4f, 8'h00);
    for (n = 0; n < 4; n++) wr_reg(8'h43 + 8'(n), 8'h5a + 8'(n));
    for (n = 0; n < 4; n++) rd_reg(8'h43 + 8'(n), 8'h5a + 8'(n));
    for (n = 0; n < 8; n++) wr_reg(8'h50 + 8'(n), 8'hff);
    rd_reg(8'h43, 8'h5a);
    rd_reg(8'h4f, 8'h00);
    rd_reg(8'h50, 8'h04);
    rd_reg(8'h51, 8'h01);
    rd_reg(8'h52, ratio[25:18]);
    rd_reg(8'h53, ratio[17:10]);
    rd_reg(8'h54, ratio[9:2]);
    rd_reg(8'h56, 8'h80);
    rd_reg(8'h57, 8'h02);
    rd_reg(8'h55, 8'h00);
    touch = 8'ha5;
    repeat (3) @(posedge ref_clk_in);
    #1 chk(pin, ~touch);
    wr_reg(8'h43, 8'h0f);
    wr_reg(8'h4f, 8'hff);
    repeat (4) @(posedge ref_clk_in);
    lo = '{0, 0, 0, 0, 0, 0, 0, 0};
    repeat (256) begin
      @(negedge ref_clk_in);
      for (n = 0; n < 8; n++) lo[n] += int'(!pin[n]);
    end
    for (n = 0; n < 8; n++) chk(8'(lo[n] >> 4), exp_lo[n]);
    wr_reg(8'h4f, 8'h0f);
    repeat (3) @(posedge ref_clk_in);
    #1 chk({4'h0, pin[7:4]}, {4'h0, ~touch[7:4]});
    @(posedge ref_clk_in) #1 reset_in = 1;
    @(posedge ref_clk_in) #1 reset_in = 0;
    rd_reg(8'h43, 8'h00);
    rd_reg(8'h4f, 8'h00);
    results;
  end
endmodule // testbench
`default_nettype wire
